// [design/aanu_defines.svh]
`ifndef AANU_DEFINES_SVH
`define AANU_DEFINES_SVH

// ************************************************************
// Register byte offsets on the APB slave
// ************************************************************
`define AANU_OFF_CMD 8'h00
`define AANU_OFF_MEMOP 8'h04
`define AANU_OFF_MEMRES 8'h08
`define AANU_OFF_COND 8'h0c
`define AANU_OFF_GP_FIRST 8'h10
`define AANU_OFF_GP_LAST 8'h24
`define AANU_OFF_PC 8'h28
`define AANU_OFF_VMCTL 8'h2c
`define AANU_OFF_STATUS 8'h30

// ************************************************************
// Register file indices (I, J, K, E, A, T)
// ************************************************************
`define AANU_IX_I 0
`define AANU_IX_E 3
`define AANU_IX_A 4
`define AANU_IX_T 5

// ************************************************************
// Field positions
// ************************************************************
`define AANU_CC_OVF 0
`define AANU_CC_ZERO 1
`define AANU_CC_NEG 2
`define AANU_CC_POS 3
`define AANU_VM_USER 0
`define AANU_ST_BUSY 0
`define AANU_ST_DIVOVF 1
`define AANU_RR_SRC_LSB 6
`define AANU_RR_DST_LSB 0

// ************************************************************
// Opcodes
// ************************************************************
`define AANU_OP_ADD_IMM_MEM 12'h03c
`define AANU_OP_ADD_RR 12'h010
`define AANU_OP_SEXT_ACC 12'h01f
`define AANU_OP_SEXT_BYTE 12'h008
`define AANU_OP_NORM 12'h02c
`define AANU_OP_DIV_IMM 9'h188
`define AANU_OP_POLY 9'h18d
`define AANU_OP_DIV_T 9'h18e
`define AANU_OP_DIV_IX 6'h31
`define AANU_OP_DIV_MEM 6'h2f
`define AANU_OP_MUL_MEM 6'h2e

// ************************************************************
// Constants and reset values
// ************************************************************
`define AANU_ZERO_EXP 24'hff_ff81
`define AANU_FULL_NEG 24'h80_0000
`define AANU_PAT_10 47'h4000_0000_0000
`define AANU_PAT_11 47'h6000_0000_0000
`define AANU_RST_WORD 24'h00_0000
`define AANU_RST_CC 4'h0
`define AANU_RST_VM 4'h0

`endif

// [design/aanu_pkg.sv]
package aanu_pkg;

	typedef enum logic [1:0] {
		AANU_IDLE,
		AANU_POLY,
		AANU_NORM
	} aanu_state_t;

	typedef struct packed {
		logic [5:0][23:0] gp;
		logic [3:0] cond;
		logic [23:0] memop;
		logic [23:0] memres;
		logic [23:0] pc;
		logic [3:0] vmctl;
		logic divovf;
		aanu_state_t state;
		logic [7:0] cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} aanu_regs_t;

endpackage

// [design/aanu_top.sv]
`timescale 1ns/100ps
`include "aanu_defines.svh"
// Contract
// - Add signed immediate byte into memory word
// - Faulting user access backs PC off one
// - Adds set sign/zero and carry overflow
// - Register add opcode, source bit 11, dest 5
// - Select fields are bit masks over I J K E A T
// - OR sources, write only selected destinations
// - Divide E:A, quotient A, remainder E
// - Immediate divisor 15-bit; timer form uses T
// - Index divide code picks I, J or K
// - E not below divisor flags divide overflow
// - Mod-2 divide E by A, count shifts
// - Zero shift count acts as one
// - Copy A23 into E, then clear A23
// - Copy A7 upward, condition from A
// - Normalize left until E22 differs, I gets -count
// - Stop on 110...0 pattern
// - Fix 100...0 by right shift, adjust count
// - Zero double gives most negative exponent
// - Overflow at start: shift right, count one
// - Multiply A by memory into E:A
// - Overflow kept in condition bit 0
module aanu_top
	import aanu_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [3:0] cc(input logic sgn, input logic zer,
		input logic ovf);
		logic [3:0] c;
		c = 4'h0;
		c[`AANU_CC_OVF] = ovf;
		c[`AANU_CC_ZERO] = zer;
		c[`AANU_CC_NEG] = sgn & ~zer;
		c[`AANU_CC_POS] = ~sgn & ~zer;
		return c;
	endfunction

	// Carry into sign differing from carry out of it
	function automatic logic add_ovf(input logic [23:0] a,
		input logic [23:0] b, input logic [23:0] s);
		return (a[23] == b[23]) && (s[23] != a[23]);
	endfunction

	aanu_regs_t r, n;
	logic acc_ph, done_ph, wr_cmd, mapped, gp_hit;
	logic [2:0] gp_ix;
	logic [11:0] op12;
	logic [8:0] op9;
	logic [5:0] op6;
	logic [23:0] aom_b, aom_s, rr_src, rr_dst, rr_s;
	logic [5:0][23:0] src_m, dst_m;
	logic is_div;
	logic [23:0] dsr;
	logic signed [46:0] dvd, dsr_x, quo, rem;
	logic signed [47:0] prod;
	logic [46:0] dd, dd_sh;
	logic [7:0] pcnt;

	assign acc_ph = psel & penable & ~r.pready;
	assign done_ph = psel & penable & r.pready;
	assign wr_cmd = done_ph & pwrite & ~r.pslverr &
		(paddr == `AANU_OFF_CMD) & (r.state == AANU_IDLE);
	assign op12 = pwdata[23:12];
	assign op9 = pwdata[23:15];
	assign op6 = pwdata[23:18];
	assign gp_hit = (paddr >= `AANU_OFF_GP_FIRST) &&
		(paddr <= `AANU_OFF_GP_LAST) && (paddr[1:0] == 2'b00);
	assign gp_ix = 3'((paddr - `AANU_OFF_GP_FIRST) >> 2);

	// ************************************************************
	// Bit-mask register selection
	// ************************************************************
	genvar g;
	for (g = 0; g < 6; g++) begin : g_sel
		assign src_m[g] = pwdata[`AANU_RR_SRC_LSB + g] ? r.gp[g] :
			`AANU_RST_WORD;
		assign dst_m[g] = pwdata[`AANU_RR_DST_LSB + g] ? r.gp[g] :
			`AANU_RST_WORD;
	end

	// Several selected registers are merged by OR, none gives zero
	assign rr_src = src_m[0] | src_m[1] | src_m[2] | src_m[3] |
		src_m[4] | src_m[5];
	assign rr_dst = dst_m[0] | dst_m[1] | dst_m[2] | dst_m[3] |
		dst_m[4] | dst_m[5];
	assign rr_s = rr_src + rr_dst;
	assign aom_b = {{16{pwdata[7]}}, pwdata[7:0]};
	assign aom_s = r.memop + aom_b;

	// ************************************************************
	// Divisor selection and datapath
	// ************************************************************
	always_comb begin
		is_div = 1'b1;
		dsr = r.memop;
		if (op9 == `AANU_OP_DIV_IMM) begin
			dsr = {9'h000, pwdata[14:0]};
		end else if (op9 == `AANU_OP_DIV_T) begin
			dsr = r.gp[`AANU_IX_T];
		end else if (op6 == `AANU_OP_DIV_IX && pwdata[17:15] >= 3'd1 &&
			pwdata[17:15] <= 3'd3) begin
			dsr = r.gp[pwdata[17:15] - 3'd1];
		end else if (op6 != `AANU_OP_DIV_MEM) begin
			is_div = 1'b0;
		end
	end

	// A23 is dropped, so the dividend is E with the low 23 bits of A
	assign dvd = $signed({r.gp[`AANU_IX_E], r.gp[`AANU_IX_A][22:0]});
	assign dsr_x = (dsr == `AANU_RST_WORD) ? 47'sd1 :
		47'($signed(dsr));
	assign quo = dvd / dsr_x;
	assign rem = dvd % dsr_x;
	assign prod = $signed(r.gp[`AANU_IX_A]) * $signed(r.memop);
	assign dd = {r.gp[`AANU_IX_E], r.gp[`AANU_IX_A][22:0]};
	assign dd_sh = {dd[45:0], 1'b0};
	assign pcnt = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		n = r;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		mapped = 1'b1;
		if (acc_ph) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (gp_hit) begin
				n.prdata = {8'h00, r.gp[gp_ix]};
			end else begin
				case (paddr)
				`AANU_OFF_CMD: n.prdata = 32'h0000_0000;
				`AANU_OFF_MEMOP: n.prdata = {8'h00, r.memop};
				`AANU_OFF_MEMRES: n.prdata = {8'h00, r.memres};
				`AANU_OFF_COND: n.prdata = {28'h000_0000, r.cond};
				`AANU_OFF_PC: n.prdata = {8'h00, r.pc};
				`AANU_OFF_VMCTL: n.prdata = {28'h000_0000, r.vmctl};
				`AANU_OFF_STATUS: n.prdata = {30'h0000_0000, r.divovf,
					r.state != AANU_IDLE};
				default: mapped = 1'b0;
				endcase
			end
			n.pslverr = ~mapped;
		end

		case (r.state)
		AANU_IDLE: ;
		AANU_POLY: begin
			// Mod-2 step: shift E, subtract A by XOR when E23 falls out
			n.gp[`AANU_IX_E] = {r.gp[`AANU_IX_E][22:0], 1'b0} ^
				(r.gp[`AANU_IX_E][23] ? r.gp[`AANU_IX_A] :
				`AANU_RST_WORD);
			n.cnt = r.cnt - 8'h01;
			if (r.cnt == 8'h01) begin
				n.state = AANU_IDLE;
			end
		end
		AANU_NORM: begin
			n.state = AANU_IDLE;
			if (dd == 47'h0000_0000_0000) begin
				n.gp[`AANU_IX_I] = `AANU_ZERO_EXP;
			end else if (dd == `AANU_PAT_10) begin
				n.gp[`AANU_IX_E] = 24'(`AANU_PAT_11 >> 23);
				n.gp[`AANU_IX_A] = `AANU_RST_WORD;
				n.gp[`AANU_IX_I] = 24'h00_0001 - {16'h0000, r.cnt};
			end else if (dd[46] != dd[45] ||
				dd == `AANU_PAT_11) begin
				n.gp[`AANU_IX_I] = `AANU_RST_WORD - {16'h0000, r.cnt};
			end else begin
				n.gp[`AANU_IX_E] = dd_sh[46:23];
				n.gp[`AANU_IX_A] = {1'b0, dd_sh[22:0]};
				n.cnt = r.cnt + 8'h01;
				n.state = AANU_NORM;
			end
			if (n.state == AANU_IDLE) begin
				n.cond = cc(n.gp[`AANU_IX_E][23],
					n.gp[`AANU_IX_E] == `AANU_RST_WORD &&
					n.gp[`AANU_IX_A][22:0] == 23'h00_0000,
					r.cond[`AANU_CC_OVF]);
			end
		end
		default: n.state = AANU_IDLE;
		endcase

		// Writes land on the completing edge; GP writes are dropped unless idle
		if (done_ph && pwrite && !r.pslverr) begin
			if (gp_hit && r.state == AANU_IDLE) begin
				n.gp[gp_ix] = pwdata[23:0];
			end
			case (paddr)
			`AANU_OFF_MEMOP: n.memop = pwdata[23:0];
			`AANU_OFF_COND: n.cond = pwdata[3:0];
			`AANU_OFF_PC: n.pc = pwdata[23:0];
			`AANU_OFF_VMCTL: n.vmctl = pwdata[3:0];
			default: ;
			endcase
		end

		if (wr_cmd) begin
			if (op12 == `AANU_OP_ADD_IMM_MEM) begin
				if (r.vmctl[`AANU_VM_USER] && |r.vmctl[3:1]) begin
					n.pc = r.pc - 24'h00_0001;
				end else begin
					n.memres = aom_s;
					n.cond = cc(aom_s[23], aom_s == `AANU_RST_WORD,
						add_ovf(r.memop, aom_b, aom_s));
				end
			end else if (op12 == `AANU_OP_ADD_RR) begin
				for (int k = 0; k < 6; k++) begin
					if (pwdata[`AANU_RR_DST_LSB + k]) begin
						n.gp[k] = rr_s;
					end
				end
				n.cond = cc(rr_s[23], rr_s == `AANU_RST_WORD,
					add_ovf(rr_src, rr_dst, rr_s));
			end else if (op12 == `AANU_OP_SEXT_ACC) begin
				n.gp[`AANU_IX_E] = {24{r.gp[`AANU_IX_A][23]}};
				n.gp[`AANU_IX_A][23] = 1'b0;
			end else if (op12 == `AANU_OP_SEXT_BYTE) begin
				n.gp[`AANU_IX_A] = {{16{r.gp[`AANU_IX_A][7]}},
					r.gp[`AANU_IX_A][7:0]};
				n.cond = cc(r.gp[`AANU_IX_A][7],
					r.gp[`AANU_IX_A][7:0] == 8'h00, r.cond[`AANU_CC_OVF]);
			end else if (op12 == `AANU_OP_NORM) begin
				if (r.cond[`AANU_CC_OVF]) begin
					// Overflowed sum: bring the lost carry back in as sign
					n.gp[`AANU_IX_E] = {~dd[46], dd[46], dd[45:24]};
					n.gp[`AANU_IX_A] = {1'b0, dd[23:1]};
					n.gp[`AANU_IX_I] = 24'h00_0001;
					n.cond = cc(~dd[46], 1'b0, 1'b1);
				end else begin
					n.cnt = 8'h00;
					n.state = AANU_NORM;
				end
			end else if (op9 == `AANU_OP_POLY) begin
				n.cnt = pcnt;
				n.state = AANU_POLY;
			end else if (op6 == `AANU_OP_MUL_MEM) begin
				n.gp[`AANU_IX_E] = prod[46:23];
				n.gp[`AANU_IX_A] = {1'b0, prod[22:0]};
				n.cond = cc(prod[47], prod == 48'h0000_0000_0000,
					r.gp[`AANU_IX_A] == `AANU_FULL_NEG &&
					r.memop == `AANU_FULL_NEG);
			end else if (is_div) begin
				// Signed compare of E against divisor; zero always fails
				if ($signed(r.gp[`AANU_IX_E]) >= $signed(dsr) ||
					dsr == `AANU_RST_WORD) begin
					n.divovf = 1'b1;
					n.cond[`AANU_CC_OVF] = 1'b1;
				end else begin
					n.divovf = 1'b0;
					n.gp[`AANU_IX_A] = quo[23:0];
					n.gp[`AANU_IX_E] = rem[23:0];
					n.cond = cc(quo[23], quo[23:0] == `AANU_RST_WORD,
						1'b0);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{gp: '0, cond: `AANU_RST_CC, memop: `AANU_RST_WORD,
				memres: `AANU_RST_WORD, pc: `AANU_RST_WORD,
				vmctl: `AANU_RST_VM, divovf: 1'b0, state: AANU_IDLE,
				cnt: 8'h00, prdata: 32'h0000_0000, pready: 1'b0,
				pslverr: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_cmd(logic [11:0] op);
		wr_cmd && op12 == op;
	endsequence

	sequence s_poly2;
		wr_cmd && op9 == `AANU_OP_POLY && pwdata[7:0] == 8'h02;
	endsequence

	sequence s_poly0;
		wr_cmd && op9 == `AANU_OP_POLY && pwdata[7:0] == 8'h00;
	endsequence

	aom_sum_a: assert property (
		s_cmd(`AANU_OP_ADD_IMM_MEM) && !(r.vmctl[0] && |r.vmctl[3:1])
		|=> r.memres == $past(r.memop) + {{16{$past(pwdata[7])}},
		$past(pwdata[7:0])})
		else $error("immediate add to memory wrong");

	pc_backoff_a: assert property (
		s_cmd(`AANU_OP_ADD_IMM_MEM) && r.vmctl[0] && |r.vmctl[3:1]
		|=> r.pc == $past(r.pc) - 24'h00_0001 && $stable(r.memres))
		else $error("pc not backed off on fault");

	rr_ovf_a: assert property (
		s_cmd(`AANU_OP_ADD_RR) |=> r.cond[`AANU_CC_OVF] ==
		($past(rr_src[23]) == $past(rr_dst[23]) &&
		$past(rr_s[23]) != $past(rr_src[23])))
		else $error("register add overflow wrong");

	rr_unsel_a: assert property (
		s_cmd(`AANU_OP_ADD_RR) && !pwdata[4] && !pwdata[5]
		|=> $stable(r.gp[`AANU_IX_A]) && $stable(r.gp[`AANU_IX_T]))
		else $error("unselected register changed");

	div_ovf_a: assert property (
		wr_cmd && is_div && $signed(r.gp[`AANU_IX_E]) >= $signed(dsr)
		|=> r.cond[`AANU_CC_OVF] && $stable(r.gp[`AANU_IX_A]))
		else $error("divide overflow not flagged");

	poly_len_a: assert property (
		s_poly2 |=> (r.state == AANU_POLY) [*2] ##1 r.state == AANU_IDLE)
		else $error("polynomial divide length wrong");

	poly_zero_a: assert property (
		s_poly0 |=> r.state == AANU_POLY ##1 r.state == AANU_IDLE)
		else $error("zero shift count not taken as one");

	sext_acc_a: assert property (
		s_cmd(`AANU_OP_SEXT_ACC) |=> r.gp[`AANU_IX_E] ==
		{24{$past(r.gp[`AANU_IX_A][23])}} && !r.gp[`AANU_IX_A][23])
		else $error("accumulator sign extend wrong");

	norm_zero_a: assert property (
		s_cmd(`AANU_OP_NORM) && !r.cond[`AANU_CC_OVF] && dd == '0
		|=> ##1 r.gp[`AANU_IX_I] == `AANU_ZERO_EXP)
		else $error("zero normalize exponent wrong");

	norm_ovf_a: assert property (
		s_cmd(`AANU_OP_NORM) && r.cond[`AANU_CC_OVF]
		|=> r.gp[`AANU_IX_I] == 24'h00_0001 && r.state == AANU_IDLE &&
		r.gp[`AANU_IX_E][23] != $past(dd[46]))
		else $error("overflow normalize wrong");

	mul_ovf_a: assert property (
		s_cmd(12'(op12)) && op6 == `AANU_OP_MUL_MEM
		|=> r.cond[`AANU_CC_OVF] == ($past(r.gp[`AANU_IX_A]) ==
		`AANU_FULL_NEG && $past(r.memop) == `AANU_FULL_NEG))
		else $error("multiply overflow wrong");

endmodule // aanu_top

// [tb/aanu_host_model.sv]
`timescale 1ns/100ps
// ************************************************************
// Decoder side: issues one APB word per transfer
// ************************************************************
module aanu_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep a stale value
		pwrite <= ~wr;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // aanu_host_model

// [tb/aanu_top_bench.sv]
`timescale 1ns/100ps
`include "aanu_defines.svh"
module aanu_top_bench;
	// ************************************************************
	// Rows: preload, command, then expected E, A, I, result, cond
	// ************************************************************
	typedef struct packed {
		logic [23:0] i, e, a, m;
		logic [3:0] c;
		logic [23:0] cmd, xe, xa, xi, xr;
		logic [3:0] xc;
	} aanu_row_t;

	localparam logic [7:0] off_e = `AANU_OFF_GP_FIRST + 8'h0c;
	localparam logic [7:0] off_a = `AANU_OFF_GP_FIRST + 8'h10;
	logic pclk;
	logic presetn;
	logic psel, penable, pwrite, pready, pslverr, e_flag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [23:0] gv [6];
	int bad_count = 0;
	int n_compared = 0;
	aanu_row_t r;
	// Condition 4'hf in a row means the command leaves it undefined
	aanu_row_t rows [22] = '{
		'{24'h1,24'h0,24'h0,24'h5,4'h0,24'h3_c0fe,
			24'h0,24'h0,24'h1,24'h3,4'h8},
		'{24'h1,24'h0,24'h0,24'h7f_ffff,4'h0,24'h3_c001,
			24'h0,24'h0,24'h1,24'h80_0000,4'h5},
		'{24'h1,24'h0,24'h0,24'h1,4'h0,24'h3_c0ff,
			24'h0,24'h0,24'h1,24'h0,4'h2},
		'{24'h11,24'h20,24'h4,24'h0,4'h0,24'h1_0858,
			24'h39,24'h39,24'h11,24'h0,4'h8},
		'{24'hff_ffff,24'h0,24'h1,24'h0,4'h0,24'h1_0401,
			24'h0,24'h1,24'h0,24'h0,4'h2},
		'{24'h1,24'h0,24'h80_1234,24'h0,4'h0,24'h1_f000,
			24'hff_ffff,24'h1234,24'h1,24'h0,4'h0},
		'{24'h1,24'h5,24'h12_3480,24'h0,4'h0,24'h8000,
			24'h5,24'hff_ff80,24'h1,24'h0,4'h4},
		'{24'h1,24'h0,24'h64,24'h0,4'h0,24'hc4_0007,
			24'h2,24'he,24'h1,24'h0,4'h8},
		'{24'h1,24'h0,24'h19,24'h0,4'h0,24'hc7_0000,
			24'h0,24'h5,24'h1,24'h0,4'h8},
		'{24'h3,24'h0,24'ha,24'h0,4'h0,24'hc4_8000,
			24'h1,24'h3,24'h3,24'h0,4'h8},
		'{24'h1,24'h0,24'h11,24'h0,4'h0,24'hc5_8000,
			24'h1,24'h4,24'h1,24'h0,4'h8},
		'{24'h2,24'hff_ffff,24'hff_fff7,24'h0,4'h0,24'hc5_0000,
			24'hff_ffff,24'hff_fffe,24'h2,24'h0,4'h4},
		'{24'h1,24'h3,24'h5,24'h3,4'h0,24'hbc_0000,
			24'h3,24'h5,24'h1,24'h0,4'h1},
		'{24'h1,24'h0,24'h14,24'h6,4'h0,24'hbc_0000,
			24'h2,24'h3,24'h1,24'h0,4'h8},
		'{24'h1,24'h0,24'h3,24'h5,4'h0,24'hb8_0000,
			24'h0,24'hf,24'h1,24'h0,4'h8},
		'{24'h1,24'h80_0000,24'hc0_0000,24'h0,4'h0,24'hc6_8002,
			24'h40_0000,24'hc0_0000,24'h1,24'h0,4'hf},
		'{24'h1,24'h80_0000,24'hc0_0000,24'h0,4'h0,24'hc6_8000,
			24'hc0_0000,24'hc0_0000,24'h1,24'h0,4'hf},
		'{24'h0,24'h1,24'h0,24'h0,4'h0,24'h2_c000,
			24'h40_0000,24'h0,24'hff_ffea,24'h0,4'h8},
		'{24'h0,24'hc0_0000,24'h0,24'h0,4'h0,24'h2_c000,
			24'hc0_0000,24'h0,24'h0,24'h0,4'h4},
		'{24'h0,24'h80_0000,24'h0,24'h0,4'h0,24'h2_c000,
			24'hc0_0000,24'h0,24'h1,24'h0,4'h4},
		'{24'h0,24'h0,24'h0,24'h0,4'h0,24'h2_c000,
			24'h0,24'h0,24'hff_ff81,24'h0,4'h2},
		'{24'h0,24'h40_0000,24'h0,24'h0,4'h1,24'h2_c000,
			24'ha0_0000,24'h0,24'h1,24'h0,4'h5}
	};

	aanu_top u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	aanu_host_model u_host (
		.pclk(pclk),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		u_host.xfer(1'b1, a, {8'h00, d}, q, e_flag);
	endtask

	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0000_0000, q, e_flag);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		rd(a);
		chk(nm, q, exp);
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		rd(`AANU_OFF_STATUS);
		while (q[0] !== 1'b0 && k < 100) begin
			rd(`AANU_OFF_STATUS);
			k++;
		end
		chk("busy", q & 32'h1, 32'h0);
	endtask

	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk("cond reset", `AANU_OFF_COND, 32'h0);
		foreach (rows[n]) begin
			r = rows[n];
			gv = '{r.i, r.i << 1, r.i << 2, r.e, r.a, r.i + 24'h4};
			for (int k = 0; k < 6; k++)
				wr(`AANU_OFF_GP_FIRST + 8'(4 * k), gv[k]);
			wr(`AANU_OFF_MEMOP, r.m);
			wr(`AANU_OFF_COND, {20'h0_0000, r.c});
			wr(`AANU_OFF_CMD, r.cmd);
			wait_idle();
			rchk("e", off_e, r.xe);
			rchk("a", off_a, r.xa);
			rchk("i", `AANU_OFF_GP_FIRST, r.xi);
			rchk("memres", `AANU_OFF_MEMRES, r.xr);
			rd(`AANU_OFF_COND);
			if (r.xc !== 4'hf)
				chk("cond", q, r.xc);
		end
		// ************************************************************
		// Awkward cases
		// ************************************************************
		for (int b = 0; b < 5; b++) begin
			wr(`AANU_OFF_PC, 24'h10);
			wr(`AANU_OFF_VMCTL, (b == 4) ? 24'h2 : 24'h1 | (24'h1 << b));
			wr(`AANU_OFF_MEMOP, 24'h5 + 24'(b));
			wr(`AANU_OFF_CMD, 24'h3_c001);
			rchk("pc", `AANU_OFF_PC, (b > 0 && b < 4) ? 32'hf : 32'h10);
			rchk("memres", `AANU_OFF_MEMRES, (b == 4) ? 32'ha : 32'h6);
		end
		wr(`AANU_OFF_VMCTL, 24'h0);
		// Write landing mid-normalize must be dropped
		wr(off_e, 24'h1);
		wr(off_a, 24'h0);
		wr(`AANU_OFF_CMD, 24'h2_c000);
		wr(off_a, 24'h123);
		wait_idle();
		rchk("a busy", off_a, 32'h0);
		wr(`AANU_OFF_COND, 24'h0);
		wr(`AANU_OFF_CMD, 24'hc4_0000);
		rchk("status", `AANU_OFF_STATUS, 32'h2);
		wr(off_a, 24'h80_0000);
		wr(`AANU_OFF_MEMOP, 24'h80_0000);
		wr(`AANU_OFF_COND, 24'h0);
		wr(`AANU_OFF_CMD, 24'hb8_0000);
		rchk("cond mul", `AANU_OFF_COND, 32'h9);
		rd(8'h34);
		chk("pslverr", {31'h0, e_flag}, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk("cond reset", `AANU_OFF_COND, 32'h0);
		stop_test();
	end
endmodule // aanu_top_bench
